// file: bcseq_top.sv
// Bus controller instruction sequencer with shared memory master port.
`timescale 1ns/10ps
`default_nettype none
`include "bcseq_cfg.svh"
module bcseq_top #(
    parameter logic [15:0] QUEUE_BASE = `BCSEQ_QUEUE_BASE,
    parameter logic [15:0] QUEUE_LEN = `BCSEQ_QUEUE_LEN
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst_n,
    // Host control and configuration.
    input wire logic bc_start,
    input wire logic [15:0] bc_start_addr,
    input wire logic [15:0] cfg_word,
    input wire logic [7:0] host_flag_set,
    input wire logic [7:0] host_flag_clr,
    output logic busy,
    output logic [7:0] cond_code,
    output logic [15:0] fixed_base,
    output logic host_irq,
    output logic [15:0] host_irq_cause,
    // Shared memory master.
    output logic mem_req,
    output logic mem_we,
    output logic [15:0] mem_addr,
    output logic [15:0] mem_wdata,
    input wire logic mem_ack,
    input wire logic [15:0] mem_rdata,
    // Message engine.
    output logic msg_start,
    output logic [15:0] msg_ptr,
    output logic msg_sync_tag_en,
    output logic [15:0] msg_sync_data,
    input wire logic msg_done,
    input wire logic msg_good,
    input wire logic [15:0] msg_block_status,
    // Time tag, trigger and queue write pointer.
    input wire logic ttag_tick,
    input wire logic external_trigger_in,
    output logic [15:0] ttag_value,
    output logic [15:0] queue_wr_ptr,
    // Remote terminal circular buffer monitor.
    input wire logic rt_word_stored,
    input wire logic [3:0] rt_cbuf_size_log2,
    input wire logic rt_half_en,
    input wire logic rt_full_en,
    output logic rt_half_irq,
    output logic rt_full_irq
);
    bcseq_pkg::bcseq_regs_t s_reg, s_next;
    logic cond_now;
    logic [3:0] opc;
    logic [15:0] q_last;

    assign opc = s_reg.op_word[`BCSEQ_OP_MSB:`BCSEQ_OP_LSB];
    assign q_last = QUEUE_BASE + QUEUE_LEN - 16'h0001;

    // Condition select: always, good, bad or a general flag, optionally inverted.
    function automatic logic cond_eval(input logic [15:0] w, input logic [7:0] f, input logic g, input logic b);
        logic [3:0] sel;
        logic r;
        sel = w[`BCSEQ_COND_MSB:0];
        r = 1'b0;
        if (sel == `BCSEQ_COND_ALWAYS) begin
            r = 1'b1;
        end else if (sel == `BCSEQ_COND_GOOD) begin
            r = g;
        end else if (sel == `BCSEQ_COND_BAD) begin
            r = b;
        end else if (sel[3]) begin
            r = f[sel[2:0]];
        end
        return r ^ w[`BCSEQ_COND_INV];
    endfunction : cond_eval

    assign cond_now = cond_eval(s_reg.op_word, s_reg.flags, s_reg.good, s_reg.bad);

    // Next-state logic for the whole sequencer.
    always_comb begin
        logic fetch;
        fetch = 1'b0;
        s_next = s_reg;
        s_next.msg_start = 1'b0;
        s_next.irq = 1'b0;
        s_next.trig_q = external_trigger_in;
        s_next.fixed_base = {cfg_word[`BCSEQ_CFG_BASE_MSB:`BCSEQ_CFG_BASE_LSB], `BCSEQ_FIXED_LOW};
        if (ttag_tick) begin
            s_next.ttag = s_reg.ttag + 16'h0001;
        end
        unique case (s_reg.state)
            bcseq_pkg::ST_IDLE: begin
                if (bc_start) begin
                    s_next.ip = bc_start_addr;
                    fetch = 1'b1;
                end
            end
            bcseq_pkg::ST_FETCH_OP: begin
                if (mem_ack) begin
                    s_next.op_word = mem_rdata;
                    s_next.mem_addr = s_reg.ip + 16'h0001;
                    s_next.state = bcseq_pkg::ST_FETCH_PAR;
                end
            end
            bcseq_pkg::ST_FETCH_PAR: begin
                if (mem_ack) begin
                    s_next.par = mem_rdata;
                    s_next.mem_req = 1'b0;
                    s_next.ip = s_reg.ip + 16'h0002;
                    s_next.state = bcseq_pkg::ST_EXEC;
                end
            end
            bcseq_pkg::ST_EXEC: begin
                fetch = 1'b1;
                if (opc == `BCSEQ_OPC_FLIP || (opc == `BCSEQ_OPC_EXEC && cond_now)) begin
                    // The pointer itself is never altered by a plain execute.
                    s_next.msg_start = 1'b1;
                    s_next.msg_ptr = s_reg.par;
                    s_next.sync_en = cfg_word[`BCSEQ_CFG_SYNC_BIT];
                    s_next.sync_data = s_reg.ttag;
                    s_next.state = bcseq_pkg::ST_MSG_WAIT;
                    fetch = 1'b0;
                end else if (cond_now) begin
                    unique case (opc)
                        `BCSEQ_OPC_FLAG: s_next.flags = (s_reg.flags & ~s_reg.par[15:8]) | s_reg.par[7:0];
                        `BCSEQ_OPC_JUMP: s_next.ip = s_reg.par;
                        `BCSEQ_OPC_PSHI, `BCSEQ_OPC_PSHT, `BCSEQ_OPC_PSHB: begin
                            s_next.mem_wdata = (opc == `BCSEQ_OPC_PSHI) ? s_reg.par :
                                (opc == `BCSEQ_OPC_PSHT) ? s_reg.ttag : s_reg.bsw;
                            s_next.mem_req = 1'b1;
                            s_next.mem_we = 1'b1;
                            s_next.mem_addr = s_reg.qptr;
                            s_next.state = bcseq_pkg::ST_PUSH_WR;
                            fetch = 1'b0;
                        end
                        `BCSEQ_OPC_PSHM: begin
                            s_next.mem_req = 1'b1;
                            s_next.mem_we = 1'b0;
                            s_next.mem_addr = s_reg.par;
                            s_next.state = bcseq_pkg::ST_PUSH_RD;
                            fetch = 1'b0;
                        end
                        `BCSEQ_OPC_IRQ: begin
                            s_next.irq = 1'b1;
                            s_next.irq_cause = s_reg.par;
                        end
                        `BCSEQ_OPC_WTRG: begin
                            s_next.state = bcseq_pkg::ST_WAIT_TRIG;
                            fetch = 1'b0;
                        end
                        `BCSEQ_OPC_LDTT: s_next.ttag = s_reg.par;
                        default: begin
                            s_next.state = bcseq_pkg::ST_IDLE;
                            fetch = 1'b0;
                        end
                    endcase
                end
            end
            bcseq_pkg::ST_MSG_WAIT: begin
                if (msg_done) begin
                    s_next.good = msg_good;
                    s_next.bad = !msg_good;
                    s_next.bsw = msg_block_status;
                    if (opc == `BCSEQ_OPC_FLIP) begin
                        s_next.state = bcseq_pkg::ST_FLIP_CHK;
                    end else begin
                        fetch = 1'b1;
                    end
                end
            end
            bcseq_pkg::ST_FLIP_CHK: begin
                // Checked after the message so a bad outcome can steer the flip.
                if (cond_now) begin
                    s_next.mem_req = 1'b1;
                    s_next.mem_we = 1'b1;
                    s_next.mem_addr = s_reg.ip - 16'h0001;
                    s_next.mem_wdata = s_reg.par ^ `BCSEQ_FLIP_MASK;
                    s_next.state = bcseq_pkg::ST_FLIP_WR;
                end else begin
                    fetch = 1'b1;
                end
            end
            bcseq_pkg::ST_FLIP_WR: begin
                fetch = mem_ack;
            end
            bcseq_pkg::ST_PUSH_RD: begin
                if (mem_ack) begin
                    s_next.mem_wdata = mem_rdata;
                    s_next.mem_we = 1'b1;
                    s_next.mem_addr = s_reg.qptr;
                    s_next.state = bcseq_pkg::ST_PUSH_WR;
                end
            end
            bcseq_pkg::ST_PUSH_WR: begin
                if (mem_ack) begin
                    s_next.qptr = (s_reg.qptr == q_last) ? QUEUE_BASE : s_reg.qptr + 16'h0001;
                    fetch = 1'b1;
                end
            end
            bcseq_pkg::ST_WAIT_TRIG: begin
                fetch = external_trigger_in && !s_reg.trig_q;
            end
            default: s_next.state = bcseq_pkg::ST_IDLE;
        endcase
        if (fetch) begin
            s_next.state = bcseq_pkg::ST_FETCH_OP;
            s_next.mem_req = 1'b1;
            s_next.mem_we = 1'b0;
            s_next.mem_addr = s_next.ip;
        end
        // Host writes come last, so a host set beats any clear in the same cycle.
        s_next.flags = (s_next.flags & ~host_flag_clr) | host_flag_set;
        s_next.cond_code = {3'h0, s_next.flags[4], 1'b0, s_next.bad, s_next.good, 1'b0};
        // Busy is registered alongside the state so the pin comes straight from a flop.
        s_next.busy = (s_next.state != bcseq_pkg::ST_IDLE);
    end

    // State register.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '0;
            s_reg.qptr <= QUEUE_BASE;
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs come straight from the state register.
    assign busy = s_reg.busy;
    assign cond_code = s_reg.cond_code;
    assign fixed_base = s_reg.fixed_base;
    assign host_irq = s_reg.irq;
    assign host_irq_cause = s_reg.irq_cause;
    assign mem_req = s_reg.mem_req;
    assign mem_we = s_reg.mem_we;
    assign mem_addr = s_reg.mem_addr;
    assign mem_wdata = s_reg.mem_wdata;
    assign msg_start = s_reg.msg_start;
    assign msg_ptr = s_reg.msg_ptr;
    assign msg_sync_tag_en = s_reg.sync_en;
    assign msg_sync_data = s_reg.sync_data;
    assign ttag_value = s_reg.ttag;
    assign queue_wr_ptr = s_reg.qptr;

    // Remote terminal buffer rollover tracking.
    bcseq_cbuf_mon bcseq_cbuf_mon_inst (
        .mclk(mclk),
        .rst_n(rst_n),
        .word_stored(rt_word_stored),
        .size_log2(rt_cbuf_size_log2),
        .half_en(rt_half_en),
        .full_en(rt_full_en),
        .half_irq(rt_half_irq),
        .full_irq(rt_full_irq)
    );

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence s_exec(logic [3:0] code);
        s_reg.state == bcseq_pkg::ST_EXEC && opc == code && cond_now;
    endsequence

    a_fixed_base: assert property (rst_n |=> fixed_base[15:10] == $past(cfg_word[15:10]) && fixed_base[9:0] == 10'h000)
        else $error("fixed area base wrong");
    a_flip_value: assert property (s_reg.state == bcseq_pkg::ST_FLIP_CHK && cond_now |=>
        mem_we && mem_req && mem_wdata == (s_reg.par ^ 16'h0010) && mem_addr == s_reg.ip - 16'h0001)
        else $error("flip write wrong");
    a_flag_four: assert property (s_exec(`BCSEQ_OPC_FLAG) and (s_reg.par == 16'h1000 && host_flag_set == 8'h00)
        |=> !cond_code[4])
        else $error("flag four not cleared");
    a_jump_take: assert property (s_exec(`BCSEQ_OPC_JUMP) |=> mem_req && mem_addr == $past(s_reg.par))
        else $error("jump target not fetched");
    a_push_imm: assert property (s_exec(`BCSEQ_OPC_PSHI) |=> mem_we && mem_wdata == $past(s_reg.par)
        && mem_addr == queue_wr_ptr)
        else $error("immediate push wrong");
    a_irq_pulse: assert property (s_exec(`BCSEQ_OPC_IRQ) |=> host_irq && host_irq_cause == $past(s_reg.par)
        ##1 !host_irq)
        else $error("host interrupt pulse wrong");
    a_trig_hold: assert property (s_reg.state == bcseq_pkg::ST_WAIT_TRIG && !external_trigger_in
        |=> s_reg.state == bcseq_pkg::ST_WAIT_TRIG)
        else $error("left trigger wait early");
    a_ttag_load: assert property (s_exec(`BCSEQ_OPC_LDTT) && !ttag_tick |=> ttag_value == $past(s_reg.par))
        else $error("time tag not loaded");
    a_qptr_step: assert property (s_reg.state == bcseq_pkg::ST_PUSH_WR && mem_ack |=>
        queue_wr_ptr == (($past(queue_wr_ptr) == q_last) ? QUEUE_BASE : $past(queue_wr_ptr) + 16'h0001))
        else $error("queue pointer step wrong");
endmodule : bcseq_top
`default_nettype wire

// file: bcseq_cfg.svh
// Constants for the bus controller instruction sequencer.
`ifndef BCSEQ_CFG_SVH
`define BCSEQ_CFG_SVH
`define BCSEQ_OPC_HALT 4'h0
`define BCSEQ_OPC_EXEC 4'h1
`define BCSEQ_OPC_FLIP 4'h2
`define BCSEQ_OPC_FLAG 4'h3
`define BCSEQ_OPC_JUMP 4'h4
`define BCSEQ_OPC_PSHI 4'h5
`define BCSEQ_OPC_PSHM 4'h6
`define BCSEQ_OPC_PSHT 4'h7
`define BCSEQ_OPC_PSHB 4'h8
`define BCSEQ_OPC_IRQ 4'h9
`define BCSEQ_OPC_WTRG 4'ha
`define BCSEQ_OPC_LDTT 4'hb
`define BCSEQ_OP_MSB 15
`define BCSEQ_OP_LSB 12
`define BCSEQ_COND_INV 4
`define BCSEQ_COND_MSB 3
`define BCSEQ_COND_ALWAYS 4'h0
`define BCSEQ_COND_GOOD 4'h1
`define BCSEQ_COND_BAD 4'h2
`define BCSEQ_FLIP_MASK 16'h0010
`define BCSEQ_CFG_BASE_MSB 15
`define BCSEQ_CFG_BASE_LSB 10
`define BCSEQ_CFG_SYNC_BIT 2
`define BCSEQ_FIXED_LOW 10'h000
`define BCSEQ_CC_FLAG4_BIT 4
`define BCSEQ_QUEUE_BASE 16'h0100
`define BCSEQ_QUEUE_LEN 16'h0040
`define BCSEQ_CBUF_ADDR_W 13
`endif

// file: bcseq_pkg.sv
// Types shared by the sequencer and its buffer monitor.
`default_nettype none
`include "bcseq_cfg.svh"
package bcseq_pkg;
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0, ST_FETCH_OP = 4'h1, ST_FETCH_PAR = 4'h2, ST_EXEC = 4'h3,
        ST_MSG_WAIT = 4'h4, ST_FLIP_CHK = 4'h5, ST_FLIP_WR = 4'h6, ST_PUSH_RD = 4'h7,
        ST_PUSH_WR = 4'h8, ST_WAIT_TRIG = 4'h9
    } bcseq_state_t;
    typedef struct packed {
        bcseq_state_t state;
        logic [15:0] ip, op_word, par, ttag, qptr, bsw;
        logic [7:0] flags;
        logic good, bad, trig_q;
        logic mem_req, mem_we;
        logic [15:0] mem_addr, mem_wdata;
        logic msg_start, sync_en;
        logic [15:0] msg_ptr, sync_data;
        logic irq, busy;
        logic [15:0] irq_cause, fixed_base;
        logic [7:0] cond_code;
    } bcseq_regs_t;
    typedef struct packed {
        logic [`BCSEQ_CBUF_ADDR_W:0] cnt;
        logic half, full;
    } bcseq_cbuf_t;
endpackage : bcseq_pkg
`default_nettype wire

// file: bcseq_cbuf_mon.sv
// Circular buffer fill monitor raising half and full rollover pulses.
`timescale 1ns/10ps
`default_nettype none
`include "bcseq_cfg.svh"
module bcseq_cbuf_mon #(
    parameter int ADDR_W = `BCSEQ_CBUF_ADDR_W
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst_n,
    // Buffer activity and setup.
    input wire logic word_stored,
    input wire logic [3:0] size_log2,
    input wire logic half_en,
    input wire logic full_en,
    // Rollover pulses.
    output logic half_irq,
    output logic full_irq
);
    bcseq_pkg::bcseq_cbuf_t s_reg, s_next;
    logic [ADDR_W:0] size;
    logic [ADDR_W:0] cnt_inc;

    // Sizes beyond the largest buffer are clamped so the count cannot overrun.
    always_comb begin
        size = (size_log2 > 4'(ADDR_W)) ? ((ADDR_W+1)'(1) << ADDR_W) : ((ADDR_W+1)'(1) << size_log2);
        cnt_inc = s_reg.cnt + (ADDR_W+1)'(1);
        s_next = s_reg;
        s_next.half = 1'b0;
        s_next.full = 1'b0;
        if (word_stored) begin
            s_next.cnt = cnt_inc;
            if (cnt_inc == (size >> 1)) begin
                s_next.half = half_en;
            end
            if (cnt_inc >= size) begin
                s_next.full = full_en;
                s_next.cnt = '0;
            end
        end
    end

    // State register.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign half_irq = s_reg.half;
    assign full_irq = s_reg.full;

    a_half_point: assert property (@(posedge mclk) disable iff (!rst_n)
        (word_stored && half_en && cnt_inc == (size >> 1)) |=> half_irq)
        else $error("half rollover pulse missing");
endmodule : bcseq_cbuf_mon
`default_nettype wire

// file: bcseq_mem_model.sv
// Shared memory and message engine model facing the sequencer.
`timescale 1ns/10ps
`default_nettype none
module bcseq_mem_model (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst_n,
    // Shared memory side.
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [15:0] mem_addr,
    input wire logic [15:0] mem_wdata,
    output logic mem_ack,
    output logic [15:0] mem_rdata,
    // Message engine side.
    input wire logic msg_start,
    input wire logic [15:0] msg_ptr,
    output logic msg_done,
    output logic msg_good,
    output logic [15:0] msg_block_status,
    // Test control.
    input wire logic [3:0] ack_dly,
    input wire logic good_cfg
);
    logic [15:0] mem [0:511];
    logic [3:0] wait_cnt;
    logic [3:0] msg_cnt;
    logic msg_busy;
    logic [15:0] bsw_hold;
    // Memory acks after ack_dly cycles; read data toggles outside the ack so stale values never match.
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mem_ack <= 1'b0;
            wait_cnt <= 4'h0;
            mem_rdata <= 16'h0000;
        end else if (mem_req && !mem_ack && wait_cnt == ack_dly) begin
            mem_ack <= 1'b1;
            wait_cnt <= 4'h0;
            mem_rdata <= mem[mem_addr[8:0]];
            if (mem_we) begin
                mem[mem_addr[8:0]] <= mem_wdata;
            end
        end else begin
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
            wait_cnt <= (mem_req && !mem_ack) ? wait_cnt + 4'h1 : 4'h0;
        end
    end
    // Each message takes six cycles; status word is the pointer with the top bit flipped.
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            msg_busy <= 1'b0;
            msg_cnt <= 4'h0;
            msg_done <= 1'b0;
            msg_good <= 1'b0;
            msg_block_status <= 16'h0000;
            bsw_hold <= 16'h0000;
        end else if (msg_start) begin
            msg_busy <= 1'b1;
            msg_cnt <= 4'h0;
            msg_done <= 1'b0;
            bsw_hold <= msg_ptr ^ 16'h8000;
        end else if (msg_busy && msg_cnt == 4'h5) begin
            msg_busy <= 1'b0;
            msg_done <= 1'b1;
            msg_good <= good_cfg;
            msg_block_status <= bsw_hold;
        end else begin
            msg_cnt <= msg_cnt + 4'h1;
            msg_done <= 1'b0;
            msg_good <= ~msg_good;
            msg_block_status <= ~msg_block_status;
        end
    end
endmodule : bcseq_mem_model
`default_nettype wire

// file: bcseq_top_bench.sv
// Self-checking testbench for the bus controller instruction sequencer.
`timescale 1ns/10ps
`default_nettype none
module bcseq_top_bench;
    logic mclk = 1'b0, rst_n = 1'b0, bc_start = 1'b0, busy, host_irq, mem_req, mem_we, mem_ack;
    logic [15:0] bc_start_addr = 16'h0000, cfg_word = 16'hfc04, fixed_base, host_irq_cause;
    logic [7:0] host_flag_set = 8'h00, host_flag_clr = 8'h00, cond_code;
    logic [15:0] mem_addr, mem_wdata, mem_rdata, msg_ptr, msg_sync_data, msg_block_status;
    logic msg_start, msg_sync_tag_en, msg_done, msg_good, ttag_tick = 1'b0;
    logic external_trigger_in = 1'b0, rt_word_stored = 1'b0, rt_half_en = 1'b1, rt_full_en = 1'b1;
    logic [15:0] ttag_value, queue_wr_ptr;
    logic [3:0] rt_cbuf_size_log2 = 4'h4;
    logic rt_half_irq, rt_full_irq, flag4_seen = 1'b0;
    int n_errors = 0, comparisons = 0, cycles = 0, irq_cnt = 0, half_cnt = 0, full_cnt = 0;
    int n_stored = 0, half_at = 0, full_at = 0;
    logic [15:0] ptr_log [$];
    // Instruction list: time tag, pushes, flag set and jump, flag clear and fall-through, flip, irq, trigger.
    localparam logic [15:0] PROG [0:33] = '{16'hb000, 16'h1234, 16'h7000, 16'h0000, 16'h5000, 16'hbeef,
        16'h6000, 16'h0080, 16'h3000, 16'h0010, 16'h400c, 16'h0010, 16'h0000, 16'h0000, 16'h0000,
        16'h0000, 16'h3000, 16'h1000, 16'h400c, 16'h0040, 16'h2002, 16'h0200, 16'h8000, 16'h0000,
        16'h1000, 16'h0300, 16'h9000, 16'h00a5, 16'ha000, 16'h0000, 16'hb000, 16'h0000, 16'h0000,
        16'h0000};

    // A four-entry queue makes the four pushes wrap the write pointer back to the base.
    bcseq_top #(.QUEUE_BASE(16'h0100), .QUEUE_LEN(16'h0004)) bcseq_top_inst (.mclk, .rst_n, .bc_start,
        .bc_start_addr, .cfg_word, .host_flag_set, .host_flag_clr, .busy, .cond_code, .fixed_base,
        .host_irq, .host_irq_cause, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata,
        .msg_start, .msg_ptr, .msg_sync_tag_en, .msg_sync_data, .msg_done, .msg_good,
        .msg_block_status, .ttag_tick, .external_trigger_in, .ttag_value, .queue_wr_ptr,
        .rt_word_stored, .rt_cbuf_size_log2, .rt_half_en, .rt_full_en, .rt_half_irq, .rt_full_irq);
    bcseq_mem_model bcseq_mem_model_inst (.mclk, .rst_n, .mem_req, .mem_we, .mem_addr, .mem_wdata,
        .mem_ack, .mem_rdata, .msg_start, .msg_ptr, .msg_done, .msg_good, .msg_block_status,
        .ack_dly(4'h2), .good_cfg(1'b0));

    always #2.5 mclk = ~mclk;

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic give_verdict();
        $display("TB: counts comparisons=%0d mismatches=%0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : give_verdict

    // Stores n words into the buffer, one pulse every four cycles so each rollover pulse is seen alone.
    task automatic store_words(input int n);
        repeat (n) begin
            @(posedge mclk);
            rt_word_stored <= 1'b1;
            n_stored <= n_stored + 1;
            @(posedge mclk);
            rt_word_stored <= 1'b0;
            repeat (2) @(posedge mclk);
        end
        repeat (4) @(posedge mclk);
    endtask : store_words

    // Watches pulses and messages; the cycle ceiling cuts a hang short.
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_errors++;
            give_verdict();
        end
        if (msg_start === 1'b1) begin
            ptr_log.push_back(msg_ptr);
            check("sync enable", 16'h0001, {15'h0000, msg_sync_tag_en});
            check("sync data", 16'h1234, msg_sync_data);
        end
        if (host_irq === 1'b1) begin
            irq_cnt++;
        end
        if (cond_code[4] === 1'b1) begin
            flag4_seen <= 1'b1;
        end
        if (rt_half_irq === 1'b1) begin
            half_cnt++;
            half_at = n_stored;
        end
        if (rt_full_irq === 1'b1) begin
            full_cnt++;
            full_at = n_stored;
        end
    end

    initial begin
        for (int i = 0; i < 34; i++) begin
            bcseq_mem_model_inst.mem[i] = PROG[i];
        end
        bcseq_mem_model_inst.mem[16'h0080] = 16'hcafe;
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (2) @(posedge mclk);
        #1;
        check("queue pointer after reset", 16'h0100, queue_wr_ptr);
        check("fixed base", 16'hfc00, fixed_base);
        $display("TEST reset done");
        @(posedge mclk);
        bc_start <= 1'b1;
        @(posedge mclk);
        bc_start <= 1'b0;
        repeat (2000) if (irq_cnt == 0) @(posedge mclk);
        check("irq cause", 16'h00a5, host_irq_cause);
        repeat (20) @(posedge mclk);
        #1;
        check("stalled busy", 16'h0001, {15'h0000, busy});
        check("time tag before trigger", 16'h1234, ttag_value);
        @(posedge mclk);
        external_trigger_in <= 1'b1;
        repeat (2000) if (busy !== 1'b0) @(posedge mclk);
        #1;
        check("time tag cleared", 16'h0000, ttag_value);
        check("queue time tag", 16'h1234, bcseq_mem_model_inst.mem[16'h0100]);
        check("queue immediate", 16'hbeef, bcseq_mem_model_inst.mem[16'h0101]);
        check("queue memory", 16'hcafe, bcseq_mem_model_inst.mem[16'h0102]);
        check("queue status", 16'h8200, bcseq_mem_model_inst.mem[16'h0103]);
        check("queue pointer wrapped", 16'h0100, queue_wr_ptr);
        check("flipped pointer", 16'h0210, bcseq_mem_model_inst.mem[21]);
        check("plain pointer kept", 16'h0300, bcseq_mem_model_inst.mem[25]);
        check("message count", 16'h0002, 16'(ptr_log.size()));
        check("first message", 16'h0200, ptr_log[0]);
        check("second message", 16'h0300, ptr_log[1]);
        check("flag four seen", 16'h0001, {15'h0000, flag4_seen});
        check("flag four cleared", 16'h0000, {15'h0000, cond_code[4]});
        check("irq count", 16'h0001, 16'(irq_cnt));
        // Host flag port: a set and then a clear of flag four, seen on the condition code.
        @(posedge mclk);
        host_flag_set <= 8'h10;
        @(posedge mclk);
        host_flag_set <= 8'h00;
        #1;
        check("host flag set", 16'h0001, {15'h0000, cond_code[4]});
        @(posedge mclk);
        host_flag_clr <= 8'h10;
        @(posedge mclk);
        host_flag_clr <= 8'h00;
        #1;
        check("host flag clear", 16'h0000, {15'h0000, cond_code[4]});
        $display("TEST program done");
        store_words(16);
        check("half count", 16'h0001, 16'(half_cnt));
        check("half position", 16'h0008, 16'(half_at));
        check("full position", 16'h0010, 16'(full_at));
        rt_half_en <= 1'b0;
        store_words(16);
        check("half masked", 16'h0001, 16'(half_cnt));
        check("full count", 16'h0002, 16'(full_cnt));
        check("second full position", 16'h0020, 16'(full_at));
        $display("TEST buffer done");
        give_verdict();
    end
endmodule : bcseq_top_bench
`default_nettype wire
